// ==== verilog/hpc_port.sv ====
// Host port channel one: host pins, slave registers, flags
// Operation
// - Port works only while port_enable is set
// - System control resets to 09, bit 3 read-only
// - Port control resets F8, upper bits fixed ones
// - Bit 2 gates channel-two input-full interrupt
// - Bit 1 gates channel-one input-full interrupt
// - Bit 0 enables fast gate, else software pin
// - Host write rising edge captures data bus
// - Address select latched as command/data bit
// - Input buffer: slave reads, host writes only
// - Output buffer: slave read/write, host read
// - Drive bus only on chip and read low, either select
// - Input full: set host write, clear slave read
// - Output full: set slave write, clear host read
// - Input full is slave interrupt source
// - Status register resets to zero
// - Status bits 3,1,0 read-only; others user
// - Buffer contents undefined after reset
// - Read: select low output, high status
`timescale 1ns/100ps
`include "hpc_regs.svh"
module hpc_port (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic chip_select_one_n,
    input wire logic host_addr_select,
    input wire logic host_write_strobe_n,
    input wire logic host_read_strobe_n,
    input wire logic [7:0] host_data_in,
    output logic [7:0] host_data_out,
    output logic host_data_oe,
    input wire logic [15:0] slave_addr,
    input wire logic slave_rd,
    input wire logic slave_wr,
    input wire logic [7:0] slave_wdata,
    output logic [7:0] slave_rdata,
    output logic in_full_irq_one,
    output logic fast_gate_enable,
    output logic in_full_irq_en_two,
    output logic gate_port_pin
);
    hpc_pkg::hpc_byte_t sysctl_q;
    hpc_pkg::hpc_byte_t portctl_q;
    hpc_pkg::hpc_byte_t in_buf_q;
    hpc_pkg::hpc_byte_t out_buf_q;
    logic [7:0] user_q;
    logic cmd_q;
    logic in_full_q;
    logic out_full_q;
    logic [2:0] cs_s;
    logic [2:0] ha_s;
    logic [2:0] wr_s;
    logic [2:0] rd_s;
    logic [7:0] dat_s1;
    logic [7:0] dat_s2;
    logic [7:0] dat_s3;
    logic port_enable;
    logic host_wr_rise;
    logic host_rd_rise;
    logic slave_rd_q;
    logic slave_wr_q;
    logic [15:0] slave_addr_q;
    logic slave_rd_fall;
    logic slave_wr_fall;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_pop;
    logic [8:0] fifo_out;
    logic drive_d;
    hpc_pkg::hpc_in_state_t in_st_q;

    assign port_enable = sysctl_q[`HPC_BIT_PORT_ENABLE];

    // Host pin synchronisers; stage 0 feeds stage 1 only
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cs_s <= 3'h7;
            ha_s <= 3'h0;
            wr_s <= 3'h7;
            rd_s <= 3'h7;
            dat_s1 <= 8'h00;
            dat_s2 <= 8'h00;
            dat_s3 <= 8'h00;
        end else begin
            cs_s <= {cs_s[1:0], chip_select_one_n};
            ha_s <= {ha_s[1:0], host_addr_select};
            wr_s <= {wr_s[1:0], host_write_strobe_n};
            rd_s <= {rd_s[1:0], host_read_strobe_n};
            dat_s1 <= host_data_in;
            dat_s2 <= dat_s1;
            dat_s3 <= dat_s2;
        end
    end

    // One pulse per synchronised strobe edge, chip one low, port enabled; read pulse only with select low
    assign host_wr_rise = wr_s[1] && !wr_s[2] && !cs_s[2]
        && port_enable;
    assign host_rd_rise = rd_s[1] && !rd_s[2] && !cs_s[2]
        && !ha_s[2] && port_enable;

    // Host writes queue data plus address select in the FIFO
    hpc_fifo #(
        .WIDTH(9),
        .DEPTH(`HPC_FIFO_DEPTH)
    ) u_in_fifo (
        .clk(core_clk),
        .rst_n(resetn),
        .in_valid(host_wr_rise),
        .in_ready(fifo_in_ready),
        .in_data({ha_s[2], dat_s3}),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out)
    );

    // Slave strobe history for falling edge detection
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            slave_rd_q <= 1'b0;
            slave_wr_q <= 1'b0;
            slave_addr_q <= 16'h0000;
        end else begin
            slave_rd_q <= slave_rd;
            slave_wr_q <= slave_wr;
            slave_addr_q <= slave_addr;
        end
    end
    assign slave_rd_fall = slave_rd_q && !slave_rd;
    assign slave_wr_fall = slave_wr_q && !slave_wr;

    // Move one FIFO entry into the input buffer when it is empty
    assign fifo_pop = fifo_out_valid && !in_full_q
        && (in_st_q == hpc_pkg::HPC_ST_IDLE);

    // Loader state: idle, load, wait for slave to drain
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            in_st_q <= hpc_pkg::HPC_ST_IDLE;
        end else begin
            case (in_st_q)
                hpc_pkg::HPC_ST_IDLE: begin
                    if (fifo_pop) begin
                        in_st_q <= hpc_pkg::HPC_ST_BUSY;
                    end
                end
                hpc_pkg::HPC_ST_BUSY: begin
                    in_st_q <= hpc_pkg::HPC_ST_DRAIN;
                end
                hpc_pkg::HPC_ST_DRAIN: begin
                    if (!in_full_q) begin
                        in_st_q <= hpc_pkg::HPC_ST_IDLE;
                    end
                end
                default: begin
                    in_st_q <= hpc_pkg::HPC_ST_IDLE;
                end
            endcase
        end
    end

    // Input buffer, no reset on contents
    always_ff @(posedge core_clk) begin
        if (fifo_pop) begin
            in_buf_q <= fifo_out[7:0];
        end
    end

    // Command/data bit follows the latched address select
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cmd_q <= 1'b0;
        end else if (fifo_pop) begin
            cmd_q <= fifo_out[8];
        end
    end

    // Input full: loading wins over a same-cycle slave read
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            in_full_q <= 1'b0;
        end else if (fifo_pop) begin
            in_full_q <= 1'b1;
        end else if (slave_rd_fall
            && slave_addr_q == `HPC_ADDR_INPUT_BUFFER_ONE) begin
            in_full_q <= 1'b0;
        end
    end

    // Output buffer, written by the slave only
    always_ff @(posedge core_clk) begin
        if (slave_wr && slave_addr == `HPC_ADDR_OUTPUT_BUFFER_ONE) begin
            out_buf_q <= slave_wdata;
        end
    end

    // Output full: slave write set wins over host read clear
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            out_full_q <= 1'b0;
        end else if (slave_wr_fall
            && slave_addr_q == `HPC_ADDR_OUTPUT_BUFFER_ONE) begin
            out_full_q <= 1'b1;
        end else if (host_rd_rise) begin
            out_full_q <= 1'b0;
        end
    end

    // Control registers written by the slave
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sysctl_q <= `HPC_SYSCTL_RESET;
            portctl_q <= `HPC_PORTCTL_RESET;
            user_q <= `HPC_STATUS_RESET;
        end else if (slave_wr) begin
            case (slave_addr)
                `HPC_ADDR_SYSTEM_CONTROL: begin
                    sysctl_q <= (slave_wdata & ~`HPC_SYSCTL_RO_MASK)
                        | (sysctl_q & `HPC_SYSCTL_RO_MASK);
                end
                `HPC_ADDR_PORT_CONTROL: begin
                    portctl_q <= slave_wdata | `HPC_PORTCTL_FIXED;
                end
                `HPC_ADDR_STATUS_ONE: begin
                    user_q <= slave_wdata & `HPC_STATUS_USER_MASK;
                end
                default: begin
                    user_q <= user_q; // input buffer ignores writes
                end
            endcase
        end
    end

    // Host bus drive and data, registered
    assign drive_d = !ha_s[1] && !cs_s[1] && !rd_s[1]
        && port_enable;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            host_data_oe <= 1'b0;
            host_data_out <= 8'h00;
        end else begin
            host_data_oe <= (!cs_s[1] && !rd_s[1] && port_enable);
            host_data_out <= drive_d ? out_buf_q
                : (user_q | {4'h0, cmd_q, 1'b0, in_full_q, out_full_q});
        end
    end

    // Slave read data, registered
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            slave_rdata <= 8'h00;
        end else begin
            case (slave_addr)
                `HPC_ADDR_SYSTEM_CONTROL: slave_rdata <= sysctl_q;
                `HPC_ADDR_PORT_CONTROL: slave_rdata <= portctl_q;
                `HPC_ADDR_INPUT_BUFFER_ONE: slave_rdata <= in_buf_q;
                `HPC_ADDR_OUTPUT_BUFFER_ONE: slave_rdata <= out_buf_q;
                `HPC_ADDR_STATUS_ONE: begin
                    slave_rdata <= user_q | {4'h0, cmd_q, 1'b0,
                        in_full_q, out_full_q};
                end
                default: slave_rdata <= 8'h00;
            endcase
        end
    end

    // Interrupt and control outputs, all from flip-flops
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            in_full_irq_one <= 1'b0;
            fast_gate_enable <= 1'b0;
            in_full_irq_en_two <= 1'b0;
            gate_port_pin <= 1'b0;
        end else begin
            in_full_irq_one <= in_full_q
                && portctl_q[`HPC_BIT_IRQ_EN_ONE];
            in_full_irq_en_two <= portctl_q[`HPC_BIT_IRQ_EN_TWO];
            fast_gate_enable <= portctl_q[`HPC_BIT_FAST_GATE];
            gate_port_pin <= portctl_q[`HPC_BIT_FAST_GATE]
                ? gate_port_pin : sysctl_q[`HPC_BIT_PORT_ENABLE];
        end
    end

    // Overflow of the host queue drops the write; flagged nowhere
    logic unused_ready;
    assign unused_ready = fifo_in_ready;
endmodule : hpc_port

// ==== common/hpc_regs.svh ====
// Register addresses, field positions, reset values for host port channel one
`ifndef HPC_REGS_SVH
`define HPC_REGS_SVH
`define HPC_ADDR_SYSTEM_CONTROL 16'hffc4
`define HPC_ADDR_PORT_CONTROL 16'hfff0
`define HPC_ADDR_INPUT_BUFFER_ONE 16'hfff4
`define HPC_ADDR_OUTPUT_BUFFER_ONE 16'hfff5
`define HPC_ADDR_STATUS_ONE 16'hfff6
`define HPC_SYSCTL_RESET 8'h09
`define HPC_SYSCTL_RO_MASK 8'h08
`define HPC_PORTCTL_RESET 8'hf8
`define HPC_PORTCTL_FIXED 8'hf8
`define HPC_STATUS_RESET 8'h00
`define HPC_STATUS_USER_MASK 8'hf4
`define HPC_BIT_PORT_ENABLE 1
`define HPC_BIT_IRQ_EN_TWO 2
`define HPC_BIT_IRQ_EN_ONE 1
`define HPC_BIT_FAST_GATE 0
`define HPC_BIT_CMD_DATA 3
`define HPC_BIT_IN_FULL 1
`define HPC_BIT_OUT_FULL 0
`define HPC_FIFO_DEPTH 4
`endif

// ==== common/hpc_pkg.sv ====
// Types shared by host port channel one
package hpc_pkg;
    typedef logic [7:0] hpc_byte_t;
    typedef enum logic [1:0] {
        HPC_ST_IDLE,
        HPC_ST_BUSY,
        HPC_ST_DRAIN
    } hpc_in_state_t;
endpackage : hpc_pkg

// ==== verilog/hpc_fifo.sv ====
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/100ps
module hpc_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    // Handshakes on each side
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];

    // Storage, no reset needed for contents
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // Pointers and fill count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule : hpc_fifo

// ==== tb/hpc_port_checker.sv ====
// Assertions on the host port channel one top-level ports
`timescale 1ns/100ps
`include "hpc_regs.svh"
module hpc_port_checker (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic chip_select_one_n,
    input wire logic host_read_strobe_n,
    input wire logic host_data_oe,
    input wire logic [15:0] slave_addr,
    input wire logic slave_rd,
    input wire logic slave_wr,
    input wire logic [7:0] slave_wdata,
    input wire logic [7:0] slave_rdata,
    input wire logic in_full_irq_one,
    input wire logic fast_gate_enable,
    input wire logic in_full_irq_en_two
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // Bus drive only inside a selected read
    a_oe_read_low: assert property (
        host_read_strobe_n [*5] |-> !host_data_oe) else $error("oe no read");
    a_oe_chip_off: assert property (
        chip_select_one_n [*5] |-> !host_data_oe) else $error("oe no chip");
    // Control bits reach their outputs
    a_gate_bit_zero: assert property (
        slave_wr && slave_addr == `HPC_ADDR_PORT_CONTROL
        |-> ##2 fast_gate_enable == $past(slave_wdata[0], 2))
        else $error("fast gate wrong");
    a_irq_en_two: assert property (
        slave_wr && slave_addr == `HPC_ADDR_PORT_CONTROL
        |-> ##2 in_full_irq_en_two == $past(slave_wdata[2], 2))
        else $error("irq enable two wrong");
    a_irq_gate_off: assert property (
        slave_wr && slave_addr == `HPC_ADDR_PORT_CONTROL && !slave_wdata[1]
        |-> ##2 !in_full_irq_one) else $error("irq not gated");
    // Fixed bits and unmapped zero read back
    a_ctl_fixed_ones: assert property (
        $past(slave_rd) && $stable(slave_addr)
        && slave_addr == `HPC_ADDR_PORT_CONTROL
        |-> slave_rdata[7:3] == 5'h1f) else $error("port control fixed");
    a_sys_bit_ro: assert property (
        $past(slave_rd) && $stable(slave_addr)
        && slave_addr == `HPC_ADDR_SYSTEM_CONTROL
        |-> slave_rdata[3]) else $error("system control bit3");
    a_unmapped_zero: assert property (
        $past(slave_rd) && $stable(slave_addr) && slave_addr == 16'h0000
        |-> slave_rdata == 8'h00) else $error("unmapped not zero");
endmodule : hpc_port_checker

// ==== tb/hpc_host_model.sv ====
// Host processor model driving channel one strobes and data bus
`timescale 1ns/100ps
module hpc_host_model (
    input wire logic core_clk,
    output logic chip_select_one_n,
    output logic host_addr_select,
    output logic host_write_strobe_n,
    output logic host_read_strobe_n,
    output logic [7:0] host_data_in,
    input wire logic [7:0] host_data_out,
    input wire logic host_data_oe
);
    // Idle: deselected, strobes high
    initial begin
        chip_select_one_n = 1'b1;
        host_addr_select = 1'b0;
        host_write_strobe_n = 1'b1;
        host_read_strobe_n = 1'b1;
        host_data_in = 8'h5a;
    end
    // Write pulse, data held well past the rise
    task automatic write(input logic a, input logic [7:0] d);
        @(posedge core_clk) #1;
        chip_select_one_n = 1'b0;
        host_addr_select = a;
        host_data_in = d;
        repeat (3) @(posedge core_clk);
        #1 host_write_strobe_n = 1'b0;
        repeat (4) @(posedge core_clk);
        #1 host_write_strobe_n = 1'b1;
        repeat (4) @(posedge core_clk);
        #1 chip_select_one_n = 1'b1;
        host_data_in = ~d; // Released bus shows no stale value
    endtask : write
    // Read pulse, bus sampled just before the strobe rises
    task automatic read(input logic a, output logic [7:0] d, output logic oe);
        @(posedge core_clk) #1;
        chip_select_one_n = 1'b0;
        host_addr_select = a;
        repeat (2) @(posedge core_clk);
        #1 host_read_strobe_n = 1'b0;
        repeat (5) @(posedge core_clk);
        #1 d = host_data_out;
        oe = host_data_oe;
        host_read_strobe_n = 1'b1;
        repeat (4) @(posedge core_clk);
        #1 chip_select_one_n = 1'b1;
    endtask : read
endmodule : hpc_host_model

// ==== tb/testbench.sv ====
// Self-checking bench for host port channel one
`timescale 1ns/100ps
`include "hpc_regs.svh"
module testbench;
    logic core_clk, resetn, chip_select_one_n, host_addr_select;
    logic host_write_strobe_n, host_read_strobe_n, host_data_oe;
    logic slave_rd, slave_wr, in_full_irq_one, fast_gate_enable;
    logic in_full_irq_en_two, gate_port_pin, oe;
    logic [7:0] host_data_in, host_data_out, slave_wdata, slave_rdata, d;
    logic [15:0] slave_addr;
    int errors, num_checks;
    hpc_port hpc_port_inst (.core_clk, .resetn, .chip_select_one_n,
        .host_addr_select, .host_write_strobe_n, .host_read_strobe_n,
        .host_data_in, .host_data_out, .host_data_oe, .slave_addr,
        .slave_rd, .slave_wr, .slave_wdata, .slave_rdata, .in_full_irq_one,
        .fast_gate_enable, .in_full_irq_en_two, .gate_port_pin);
    hpc_host_model hpc_host_model_inst (.core_clk, .chip_select_one_n,
        .host_addr_select, .host_write_strobe_n, .host_read_strobe_n,
        .host_data_in, .host_data_out, .host_data_oe);
    // Clock
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Slave write: one cycle of strobe, address held past its fall
    task automatic s_wr(logic [15:0] a, logic [7:0] v);
        @(posedge core_clk) #1;
        slave_addr = a;
        slave_wdata = v;
        slave_wr = 1'b1;
        @(posedge core_clk) #1;
        slave_wr = 1'b0;
        @(posedge core_clk) #1;
    endtask : s_wr
    // Slave read and compare
    task automatic rchk(logic [15:0] a, logic [7:0] exp, string what);
        @(posedge core_clk) #1;
        slave_addr = a;
        slave_rd = 1'b1;
        repeat (2) @(posedge core_clk);
        #1 chk(what, exp, slave_rdata);
        slave_rd = 1'b0;
        @(posedge core_clk) #1;
    endtask : rchk
    task automatic t_reset();
        rchk(`HPC_ADDR_SYSTEM_CONTROL, 8'h09, "sysctl");
        rchk(`HPC_ADDR_PORT_CONTROL, 8'hf8, "portctl");
        rchk(`HPC_ADDR_STATUS_ONE, 8'h00, "status");
        rchk(16'h0000, 8'h00, "unmapped");
    endtask : t_reset
    task automatic t_regs();
        s_wr(`HPC_ADDR_PORT_CONTROL, 8'h00);
        s_wr(`HPC_ADDR_PORT_CONTROL, 8'h07);
        rchk(`HPC_ADDR_PORT_CONTROL, 8'hff, "portctl wr");
        chk("fast gate", 8'h01, {7'h0, fast_gate_enable});
        chk("irq en two", 8'h01, {7'h0, in_full_irq_en_two});
        s_wr(`HPC_ADDR_SYSTEM_CONTROL, 8'h00);
        rchk(`HPC_ADDR_SYSTEM_CONTROL, 8'h08, "sysctl ro");
        s_wr(`HPC_ADDR_SYSTEM_CONTROL, 8'h02);
        rchk(`HPC_ADDR_SYSTEM_CONTROL, 8'h0a, "enable");
        s_wr(`HPC_ADDR_STATUS_ONE, 8'hff);
        rchk(`HPC_ADDR_STATUS_ONE, 8'hf4, "user bits");
    endtask : t_regs
    // Command then data from the host, slave write to input ignored
    task automatic t_host_in();
        hpc_host_model_inst.write(1'b1, 8'ha5);
        s_wr(`HPC_ADDR_INPUT_BUFFER_ONE, 8'h11);
        rchk(`HPC_ADDR_STATUS_ONE, 8'hfe, "cmd full");
        chk("irq set", 8'h01, {7'h0, in_full_irq_one});
        rchk(`HPC_ADDR_INPUT_BUFFER_ONE, 8'ha5, "in data");
        rchk(`HPC_ADDR_STATUS_ONE, 8'hfc, "full clr");
        chk("irq clr", 8'h00, {7'h0, in_full_irq_one});
        hpc_host_model_inst.write(1'b0, 8'h3e);
        rchk(`HPC_ADDR_STATUS_ONE, 8'hf6, "data full");
        rchk(`HPC_ADDR_INPUT_BUFFER_ONE, 8'h3e, "in data");
    endtask : t_host_in
    // Queued host writes drain in order
    task automatic t_fifo();
        for (int i = 1; i <= 3; i++)
            hpc_host_model_inst.write(1'b0, 8'(i));
        for (int i = 1; i <= 3; i++) begin
            repeat (3) @(posedge core_clk);
            rchk(`HPC_ADDR_INPUT_BUFFER_ONE, 8'(i), "queued");
        end
        repeat (3) @(posedge core_clk);
        rchk(`HPC_ADDR_STATUS_ONE, 8'hf4, "drained");
    endtask : t_fifo
    task automatic t_out();
        s_wr(`HPC_ADDR_OUTPUT_BUFFER_ONE, 8'h3c);
        rchk(`HPC_ADDR_OUTPUT_BUFFER_ONE, 8'h3c, "out rw");
        rchk(`HPC_ADDR_STATUS_ONE, 8'hf5, "out full");
        hpc_host_model_inst.read(1'b0, d, oe);
        chk("host out", 8'h3c, d);
        chk("oe", 8'h01, {7'h0, oe});
        hpc_host_model_inst.read(1'b1, d, oe);
        chk("host status", 8'hf4, d);
        rchk(`HPC_ADDR_STATUS_ONE, 8'hf4, "out clr");
    endtask : t_out
    // Disabled port ignores the host
    task automatic t_off();
        s_wr(`HPC_ADDR_PORT_CONTROL, 8'h06);
        chk("gate pin on", 8'h01, {7'h0, gate_port_pin});
        s_wr(`HPC_ADDR_SYSTEM_CONTROL, 8'h08);
        chk("gate pin off", 8'h00, {7'h0, gate_port_pin});
        hpc_host_model_inst.write(1'b1, 8'h77);
        rchk(`HPC_ADDR_STATUS_ONE, 8'hf4, "off write");
        hpc_host_model_inst.read(1'b0, d, oe);
        chk("off oe", 8'h00, {7'h0, oe});
    endtask : t_off
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : summarize
    // Main sequence
    initial begin
        errors = 0;
        num_checks = 0;
        resetn = 1'b0;
        slave_addr = 16'h0000;
        slave_rd = 1'b0;
        slave_wr = 1'b0;
        slave_wdata = 8'h00;
        repeat (12) @(posedge core_clk);
        #1 resetn = 1'b1;
        t_reset();
        t_regs();
        t_host_in();
        t_fifo();
        t_out();
        t_off();
        summarize();
    end
    // Watchdog
    initial begin
        repeat (4000) @(posedge core_clk);
        errors++;
        summarize();
    end
endmodule : testbench
bind hpc_port hpc_port_checker hpc_port_checker_inst (.core_clk, .resetn,
    .chip_select_one_n, .host_read_strobe_n, .host_data_oe, .slave_addr,
    .slave_rd, .slave_wr, .slave_wdata, .slave_rdata, .in_full_irq_one,
    .fast_gate_enable, .in_full_irq_en_two);
